// ==== core/secfg_pkg.sv ====
// Constants and carriers for the settings loader.
// Assumes one 10 MHz clock and an 8-bit register address space.
package secfg_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 10000000;
  localparam int TEST_WINDOW_MS   = 10;
  // Longest time: round down
  localparam int TEST_WINDOW_CYC  = (CLK_HZ / 1000) * TEST_WINDOW_MS;

  // ----------------------------------------------------------------
  // Address map and magic answers
  // ----------------------------------------------------------------
  localparam int         AW            = 8;
  localparam int         DW            = 8;
  localparam int         NREG          = 256;
  localparam logic [7:0] POLL_ADDR     = 8'h0f;
  localparam logic [7:0] POLL_ANSWER   = 8'ha5;
  localparam logic [7:0] WREN_ADDR     = 8'he4;
  localparam logic [7:0] WREN_ANSWER   = 8'ha6;
  localparam logic [7:0] BLANK_KEY     = 8'hff;
  localparam logic [7:0] IMAGE_FIRST   = 8'h02;
  localparam logic [7:0] STREAM_REG    = 8'hd0;
  localparam int         STREAM_BIT    = 2;
  localparam logic [8:0] IMAGE_MAX     = 9'h100;

  // ----------------------------------------------------------------
  // Option byte fields
  // ----------------------------------------------------------------
  localparam int OPT_NVM_READ_BIT = 0;
  localparam int OPT_SERIAL_BIT   = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } secfg_req_t;

  typedef enum logic [2:0] {
    LD_WAIT0,
    LD_WAIT1,
    LD_SIZE_HI,
    LD_SIZE_LO,
    LD_KEY,
    LD_VAL,
    LD_DONE
  } secfg_ld_t;
endpackage

// ==== core/secfg_loader.sv ====
// Power-up settings loader with factory test entry and write unlock.
// Assumes a byte-wide nonvolatile image read port with one cycle of
// latency, and a register master on the same clock.
//
// Functional notes
// [RULE1] Copy stored settings at power-up automatically
// [RULE2] New settings apply only after power cycle
// [RULE3] Master changes settings via working registers
// [RULE4] Poll 0x0F within 10 ms enters test
// [RULE5] Test state answers poll with 0xA5
// [RULE6] Default is standalone, serial path inactive
// [RULE7] Master reads option bank without stop
// [RULE8] Master keeps reserved option bits unchanged
// [RULE9] Read 0xE4 returns 0xA6 when unlocked
// [RULE10] Master writes memory only after both confirmations
// [RULE11] Master writes one 16-byte row per transfer
// [RULE12] Master pauses between row writes
// [RULE13] First two image bytes give size
// [RULE14] Settings stored as register, value pairs
// [RULE15] Bytes 0x26/0x27 hold channel zero threshold
// [RULE16] Option bank selects serial mode, memory read
// [RULE17] Stored setting selects streamed operation
// [RULE18] Master waits milliseconds, verifies rows
`timescale 1ns/100ps

module secfg_loader #(
  parameter int TEST_WINDOW_CYCLES = secfg_pkg::TEST_WINDOW_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire secfg_pkg::secfg_req_t    req,
  output logic [secfg_pkg::DW-1:0]      rdata,
  input  wire logic [7:0]               otp_option_byte,
  output logic [secfg_pkg::AW-1:0]      nvm_addr,
  output logic                          nvm_rd,
  input  wire logic [7:0]               nvm_rdata,
  output logic                          load_busy,
  output logic                          load_done,
  output logic                          factory_test_state,
  output logic                          nvm_write_en,
  output logic                          serial_mode,
  output logic                          stream_mode
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  // Async assert, two-stage release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Option pins
  // ----------------------------------------------------------------
  logic [7:0] opt_meta_ff;
  logic [7:0] opt_ff;

  // Straps are static; two flops keep metastability out
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      opt_meta_ff <= 8'h00;
      opt_ff      <= 8'h00;
    end else begin
      opt_meta_ff <= otp_option_byte;
      opt_ff      <= opt_meta_ff;
    end
  end

  // [RULE16] Option bank fields
  // [RULE6] Standalone unless serial bit set
  assign serial_mode = opt_ff[secfg_pkg::OPT_SERIAL_BIT];

  // ----------------------------------------------------------------
  // Loader sequencer
  // ----------------------------------------------------------------
  secfg_pkg::secfg_ld_t        st_ff, nxt_st;
  logic [8:0]                  idx_ff, nxt_idx;
  logic [8:0]                  size_ff, nxt_size;
  logic [7:0]                  key_ff, nxt_key;
  logic                        phase_ff, nxt_phase;
  logic                        ld_we;
  logic [7:0]                  ld_addr;
  logic [7:0]                  ld_data;

  // Each byte takes two cycles: issue, then capture
  always_comb begin
    nxt_st    = st_ff;
    nxt_idx   = idx_ff;
    nxt_size  = size_ff;
    nxt_key   = key_ff;
    nxt_phase = phase_ff;
    ld_we     = 1'b0;
    ld_addr   = key_ff;
    ld_data   = nvm_rdata;
    case (st_ff)
      // Two cycles here so the strap's second flop is loaded
      // before the enable bit is looked at in LD_WAIT1
      secfg_pkg::LD_WAIT0: begin
        nxt_phase = ~phase_ff;
        if (phase_ff) begin
          nxt_st = secfg_pkg::LD_WAIT1;
        end
      end
      secfg_pkg::LD_WAIT1: begin
        // [RULE16] Memory read enable gates the load
        if (opt_ff[secfg_pkg::OPT_NVM_READ_BIT]) begin
          nxt_st    = secfg_pkg::LD_SIZE_HI;
          nxt_idx   = 9'h000;
          nxt_phase = 1'b0;
        end else begin
          nxt_st = secfg_pkg::LD_DONE;
        end
      end
      secfg_pkg::LD_SIZE_HI, secfg_pkg::LD_SIZE_LO,
      secfg_pkg::LD_KEY, secfg_pkg::LD_VAL: begin
        nxt_phase = ~phase_ff;
        if (phase_ff) begin
          nxt_idx = idx_ff + 9'h001;
          case (st_ff)
            // [RULE13] Image size from first two bytes
            secfg_pkg::LD_SIZE_HI: begin
              nxt_size = {nvm_rdata[0], 8'h00};
              nxt_st   = secfg_pkg::LD_SIZE_LO;
            end
            secfg_pkg::LD_SIZE_LO: begin
              nxt_size = size_ff | {1'b0, nvm_rdata};
              nxt_st   = secfg_pkg::LD_KEY;
            end
            // [RULE14] First byte names the target
            secfg_pkg::LD_KEY: begin
              nxt_key = nvm_rdata;
              nxt_st  = secfg_pkg::LD_VAL;
            end
            default: begin
              // [RULE1] Value lands in working register unless the key is 0xFF
              // [RULE15] Threshold pair loads like any other
              ld_we  = (key_ff != secfg_pkg::BLANK_KEY);
              nxt_st = secfg_pkg::LD_KEY;
            end
          endcase
          // Stop at image end or top of address space
          if (st_ff != secfg_pkg::LD_SIZE_HI &&
              (idx_ff + 9'h001 >= nxt_size ||
               idx_ff + 9'h001 >= secfg_pkg::IMAGE_MAX) &&
              st_ff != secfg_pkg::LD_SIZE_LO) begin
            nxt_st = secfg_pkg::LD_DONE;
          end
        end
      end
      // [RULE2] Terminal until the next reset
      secfg_pkg::LD_DONE: nxt_st = secfg_pkg::LD_DONE;
      default:             nxt_st = secfg_pkg::LD_DONE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff    <= secfg_pkg::LD_WAIT0;
      idx_ff   <= 9'h000;
      size_ff  <= 9'h000;
      key_ff   <= 8'h00;
      phase_ff <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      idx_ff   <= nxt_idx;
      size_ff  <= nxt_size;
      key_ff   <= nxt_key;
      phase_ff <= nxt_phase;
    end
  end

  // Memory port driven from state flops
  assign load_busy = (st_ff != secfg_pkg::LD_DONE);
  assign load_done = (st_ff == secfg_pkg::LD_DONE);
  assign nvm_rd    = !phase_ff && load_busy &&
                     st_ff != secfg_pkg::LD_WAIT0 &&
                     st_ff != secfg_pkg::LD_WAIT1;
  assign nvm_addr  = idx_ff[7:0];

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  logic [7:0] wreg_ff [secfg_pkg::NREG];
  logic       bus_we;

  // Bus writes are dropped while loading; the loader owns the file
  // [RULE3] Runtime changes go to working registers
  assign bus_we = req.wr && !load_busy;

  for (genvar i = 0; i < secfg_pkg::NREG; i++) begin : g_reg
    logic [7:0] nxt_wreg;
    always_comb begin
      nxt_wreg = wreg_ff[i];
      if (ld_we && ld_addr == 8'(i)) begin
        nxt_wreg = ld_data;
      end else if (bus_we && req.addr == 8'(i)) begin
        nxt_wreg = req.wdata;
      end
    end
    always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        wreg_ff[i] <= 8'h00;
      end else begin
        wreg_ff[i] <= nxt_wreg;
      end
    end
  end

  // [RULE17] Streamed operation from a stored setting
  assign stream_mode =
    wreg_ff[secfg_pkg::STREAM_REG][secfg_pkg::STREAM_BIT];

  // ----------------------------------------------------------------
  // Test state, unlock and read data
  // ----------------------------------------------------------------
  logic [31:0] win_ff, nxt_win;
  logic        tst_ff, nxt_tst;
  logic        wen_ff, nxt_wen;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        win_open;

  assign win_open = (win_ff < 32'(TEST_WINDOW_CYCLES));

  always_comb begin
    nxt_win   = win_open ? win_ff + 32'h0000_0001 : win_ff;
    nxt_tst   = tst_ff;
    nxt_wen   = wen_ff;
    nxt_rdata = 8'h00;
    if (req.rd) begin
      nxt_rdata = wreg_ff[req.addr];
      // [RULE4] Poll inside the power-up window
      if (req.addr == secfg_pkg::POLL_ADDR && (win_open || tst_ff)) begin
        nxt_tst = 1'b1;
        // [RULE5] Test state answer
        nxt_rdata = secfg_pkg::POLL_ANSWER;
      end
      // [RULE9] Unlock only from test state
      if (req.addr == secfg_pkg::WREN_ADDR && tst_ff) begin
        nxt_wen   = 1'b1;
        nxt_rdata = secfg_pkg::WREN_ANSWER;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      win_ff   <= 32'h0000_0000;
      tst_ff   <= 1'b0;
      wen_ff   <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      win_ff   <= nxt_win;
      tst_ff   <= nxt_tst;
      wen_ff   <= nxt_wen;
      rdata_ff <= nxt_rdata;
    end
  end

  assign factory_test_state = tst_ff;
  assign nvm_write_en       = wen_ff;
  assign rdata              = rdata_ff;

endmodule

// ==== sim/secfg_loader_checker.sv ====
// Port checker for the settings loader.
// Assumes a bind onto secfg_loader; sees its ports only.
`timescale 1ns/100ps
module secfg_checker #(
  parameter int TEST_WINDOW_CYCLES = 50
) (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire secfg_pkg::secfg_req_t req,
  input wire logic [7:0]            rdata,
  input wire logic [7:0]            otp_option_byte,
  input wire logic [7:0]            nvm_addr,
  input wire logic                  nvm_rd,
  input wire logic [7:0]            nvm_rdata,
  input wire logic                  load_busy,
  input wire logic                  load_done,
  input wire logic                  factory_test_state,
  input wire logic                  nvm_write_en,
  input wire logic                  serial_mode,
  input wire logic                  stream_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_poll;
    req.rd && req.addr == secfg_pkg::POLL_ADDR |=>
      !factory_test_state || rdata == secfg_pkg::POLL_ANSWER;
  endproperty
  a_poll: assert property (p_poll)
    else $error("poll answer wrong");
  property p_wren;
    req.rd && req.addr == secfg_pkg::WREN_ADDR && factory_test_state
      |=> rdata == secfg_pkg::WREN_ANSWER && nvm_write_en;
  endproperty
  a_wren: assert property (p_wren)
    else $error("unlock answer wrong");
  property p_gate;
    nvm_write_en |-> factory_test_state;
  endproperty
  a_gate: assert property (p_gate)
    else $error("unlock outside test state");
  property p_idle;
    !req.rd |=> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data without read");
  property p_busy;
    load_done != load_busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy and done disagree");
  property p_hold;
    load_done |=> load_done && !nvm_rd;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reload while running");
  property p_test;
    factory_test_state |=> factory_test_state;
  endproperty
  a_test: assert property (p_test)
    else $error("test state lost");
  property p_serial;
    load_done |-> serial_mode == otp_option_byte[1];
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial mode off strap");
  property p_fetch;
    nvm_rd |=> !nvm_rd;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch without capture cycle");
endmodule

bind secfg_loader secfg_checker #(
  .TEST_WINDOW_CYCLES(TEST_WINDOW_CYCLES)
) u_chk (
  .clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
  .otp_option_byte(otp_option_byte), .nvm_addr(nvm_addr),
  .nvm_rd(nvm_rd), .nvm_rdata(nvm_rdata), .load_busy(load_busy),
  .load_done(load_done), .factory_test_state(factory_test_state),
  .nvm_write_en(nvm_write_en), .serial_mode(serial_mode),
  .stream_mode(stream_mode)
);

// ==== sim/secfg_nvm_model.sv ====
// Image memory model behind the loader's byte fetch port.
// Assumes one cycle of read latency; nothing writes it here.
`timescale 1ns/100ps
module secfg_nvm_model (
  input  wire logic       clk,
  input  wire logic       nvm_rd,
  input  wire logic [7:0] nvm_addr,
  output logic      [7:0] nvm_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_ff = 8'h3c;
  logic       hit_ff = 1'b0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    mem[0] = 8'h00;
    mem[1] = 8'h08;
    mem[2] = 8'hd0;
    mem[3] = 8'h04;
    mem[5] = 8'h55;
    mem[6] = 8'h98;
    mem[7] = 8'h0a;
  end
  // Idle shows inverted data so stale bytes cannot pass
  always_ff @(posedge clk) begin
    hit_ff <= nvm_rd;
    if (nvm_rd) begin
      last_ff <= mem[nvm_addr];
    end
  end
  assign nvm_rdata = hit_ff ? last_ff : ~last_ff;
endmodule

// ==== sim/settings_eeprom_programming_bench.sv ====
// Self-checking bench for the settings loader.
// Assumes the image model and checker files are compiled first.
`timescale 1ns/100ps
module settings_eeprom_programming_bench;
  logic                  clk = 1'b0;
  logic                  resetn = 1'b0;
  secfg_pkg::secfg_req_t req = '0;
  logic [7:0]            otp = 8'h03;
  logic [7:0]            rdata, nvm_addr, nvm_rdata, d;
  logic                  nvm_rd, busy, done, fts, wren, ser, strm;
  int                    err_total = 0;
  int                    check_count = 0;

  always #50 clk = ~clk;

  secfg_loader #(.TEST_WINDOW_CYCLES(50)) dut (
    .clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
    .otp_option_byte(otp), .nvm_addr(nvm_addr), .nvm_rd(nvm_rd),
    .nvm_rdata(nvm_rdata), .load_busy(busy), .load_done(done),
    .factory_test_state(fts), .nvm_write_en(wren),
    .serial_mode(ser), .stream_mode(strm)
  );
  secfg_nvm_model u_nvm (
    .clk(clk), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
    .nvm_rdata(nvm_rdata)
  );

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  // One bus cycle; read data lands the cycle after
  task automatic bus(logic w, logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic wait_load;
    for (int n = 0; n < 200 && done !== 1'b1; n++) @(posedge clk);
    if (done !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask

  // Test entry and unlock inside the window
  task automatic t_unlock;
    bus(0, secfg_pkg::WREN_ADDR, 8'h00);
    chk("early unlock", 8'h00, {7'h0, wren});
    bus(0, secfg_pkg::POLL_ADDR, 8'h00);
    chk("poll", secfg_pkg::POLL_ANSWER, d);
    chk("test state", 8'h01, {7'h0, fts});
    bus(0, secfg_pkg::WREN_ADDR, 8'h00);
    chk("unlock", secfg_pkg::WREN_ANSWER, d);
    chk("write enable", 8'h01, {7'h0, wren});
  endtask

  task automatic t_load;
    wait_load();
    chk("stream", 8'h01, {7'h0, strm});
    chk("serial", 8'h01, {7'h0, ser});
    bus(0, 8'h98, 8'h00);
    chk("stored reg", 8'h0a, d);
  endtask

  // Live writes stick; no reload while running
  task automatic t_live;
    bus(1, 8'h98, 8'h33);
    bus(0, 8'h98, 8'h00);
    chk("live write", 8'h33, d);
    repeat (40) @(posedge clk);
    bus(0, 8'h98, 8'h00);
    chk("no reload", 8'h33, d);
  endtask

  // Second power-up, strap standalone, poll too late
  task automatic t_late;
    @(posedge clk);
    resetn <= 1'b0;
    otp    <= 8'h01;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (60) @(posedge clk);
    bus(0, secfg_pkg::POLL_ADDR, 8'h00);
    chk("late poll", 8'h00, {7'h0, fts});
    wait_load();
    chk("standalone", 8'h00, {7'h0, ser});
    bus(0, 8'h98, 8'h00);
    chk("reloaded", 8'h0a, d);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_unlock();
    t_load();
    t_live();
    t_late();
    finish_test();
  end
endmodule
